// ===== design/art_pkg.sv
package art_pkg;

   // Special function register addresses of the timer
   localparam logic [7:0] ART_ADDR_CONTROL     = 8'hC8;
   localparam logic [7:0] ART_ADDR_RELOAD_LOW  = 8'hCA;
   localparam logic [7:0] ART_ADDR_RELOAD_HIGH = 8'hCB;
   localparam logic [7:0] ART_ADDR_COUNT_LOW   = 8'hCC;
   localparam logic [7:0] ART_ADDR_COUNT_HIGH  = 8'hCD;

   // Control register field positions
   localparam int ART_BIT_HIGH_FLAG  = 7;
   localparam int ART_BIT_LOW_FLAG   = 6;
   localparam int ART_BIT_LOW_IEN    = 5;
   localparam int ART_BIT_CAPTURE_EN = 4;
   localparam int ART_BIT_SPLIT      = 3;
   localparam int ART_BIT_RUN        = 2;
   localparam int ART_BIT_EXT_CLK    = 0;

   // Clock control register field positions
   localparam int ART_BIT_HIGH_CLK_SEL = 5;
   localparam int ART_BIT_LOW_CLK_SEL  = 4;

   // Writable bits of the control register; bit 1 is unused
   localparam logic [7:0] ART_CONTROL_WMASK = 8'hFD;

   // Reset values
   localparam logic [7:0] ART_RESET_BYTE = 8'h00;
   localparam logic [3:0] ART_RESET_DIV  = 4'h0;

   // Core clock prescaler
   localparam logic [3:0] ART_DIV12_LAST = 4'hB;

   // Byte wrap detection
   localparam logic [7:0] ART_BYTE_ALL_ONES = 8'hFF;
   localparam logic [7:0] ART_BYTE_ONE      = 8'h01;

   // Register access from the processor core
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } art_sfr_req_t;

   // Mode decoded from the control register
   typedef enum logic [1:0] {
      ART_MODE_FULL    = 2'b00,
      ART_MODE_SPLIT   = 2'b01,
      ART_MODE_CAPTURE = 2'b10
   } art_mode_t;

endpackage

// ===== design/art_timer.sv
`timescale 1ns/1ps
module art_timer
   import art_pkg::*;
(
   // Clock and reset
   input  wire logic       core_clk_in,
   input  wire logic       rstn_in,
   // Special function register access
   input  wire logic       sfr_wr_in,
   input  wire logic       sfr_rd_in,
   input  wire logic [7:0] sfr_addr_in,
   input  wire logic [7:0] sfr_wdata_in,
   output logic      [7:0] sfr_rdata_out,
   // Clock control bits and interrupt enable from the core
   input  wire logic       high_byte_clock_select_in,
   input  wire logic       low_byte_clock_select_in,
   input  wire logic       timer_interrupt_enable_in,
   // External oscillator divided by 8, asynchronous
   input  wire logic       ext_div8_in,
   // Interrupt request to the core
   output logic            timer_irq_out
);

   art_sfr_req_t req;
   art_mode_t    mode;

   logic [7:0] control_r;
   logic [7:0] reload_low_r;
   logic [7:0] reload_high_r;
   logic [7:0] count_low_r;
   logic [7:0] count_high_r;
   logic [7:0] sfr_rdata_r;
   logic       timer_irq_r;
   logic [3:0] div12_r;
   logic       tick12_r;
   logic       ext_meta_r;
   logic       ext_sync_r;
   logic       ext_prev_r;

   logic       ext_rise;
   logic       ext_fall;
   logic       split;
   logic       run;
   logic       non_core_tick;
   logic       low_tick;
   logic       high_tick;
   logic       low_step;
   logic       high_step;
   logic       low_wrap;
   logic       high_wrap;
   logic       full_wrap;
   logic       capture_evt;
   logic       wr_control;
   logic       high_flag_set;
   logic       low_flag_set;
   logic       irq_nxt;

   assign req.wr    = sfr_wr_in;
   assign req.rd    = sfr_rd_in;
   assign req.addr  = sfr_addr_in;
   assign req.wdata = sfr_wdata_in;

   assign split = control_r[ART_BIT_SPLIT];
   assign run   = control_r[ART_BIT_RUN];

   always_comb
   begin
      if (control_r[ART_BIT_CAPTURE_EN])
      begin
         mode = ART_MODE_CAPTURE;
      end
      else if (split)
      begin
         mode = ART_MODE_SPLIT;
      end
      else
      begin
         mode = ART_MODE_FULL;
      end
   end

   always_ff @(posedge core_clk_in)
   begin
      if (!rstn_in)
      begin
         ext_meta_r <= 1'b0;
         ext_sync_r <= 1'b0;
         ext_prev_r <= 1'b0;
      end
      else
      begin
         ext_meta_r <= ext_div8_in;
         ext_sync_r <= ext_meta_r;
         ext_prev_r <= ext_sync_r;
      end
   end

   // Rising edge advances the count; falling edge captures
   assign ext_rise = ext_sync_r & ~ext_prev_r;
   assign ext_fall = ~ext_sync_r & ext_prev_r;

   // Divide-by-12 prescaler, one pulse every twelve core cycles
   always_ff @(posedge core_clk_in)
   begin
      if (!rstn_in)
      begin
         div12_r  <= ART_RESET_DIV;
         tick12_r <= 1'b0;
      end
      else
      begin
         tick12_r <= (div12_r == ART_DIV12_LAST);
         if (div12_r == ART_DIV12_LAST)
         begin
            div12_r <= ART_RESET_DIV;
         end
         else
         begin
            div12_r <= div12_r + 4'h1;
         end
      end
   end

   assign non_core_tick = control_r[ART_BIT_EXT_CLK] ? ext_rise : tick12_r;

   always_comb
   begin
      low_tick  = low_byte_clock_select_in ? 1'b1 : non_core_tick;
      high_tick = low_tick;
      case (mode)
         ART_MODE_SPLIT:
         begin
            high_tick = high_byte_clock_select_in ? 1'b1 : non_core_tick;
         end
         ART_MODE_CAPTURE:
         begin
            // core or core over 12 only
            low_tick  = low_byte_clock_select_in ? 1'b1 : tick12_r;
            high_tick = low_tick;
         end
         default:
         begin
            high_tick = low_tick;
         end
      endcase
   end

   assign low_step  = split ? low_tick : (run & low_tick);
   assign high_step = split ? (run & high_tick) : (run & low_tick);

   assign low_wrap  = low_step & (count_low_r == ART_BYTE_ALL_ONES);
   assign high_wrap = split ? (high_step & (count_high_r == ART_BYTE_ALL_ONES))
                            : (low_wrap & (count_high_r == ART_BYTE_ALL_ONES));
   assign full_wrap = ~split & high_wrap;

   assign capture_evt = control_r[ART_BIT_CAPTURE_EN] & ext_fall;

   assign wr_control = req.wr & (req.addr == ART_ADDR_CONTROL);

   // low counter steps once per enable pulse; high counter does in split mode, otherwise once per low byte wrap
   always_ff @(posedge core_clk_in)
   begin
      if (!rstn_in)
      begin
         count_low_r  <= ART_RESET_BYTE;
         count_high_r <= ART_RESET_BYTE;
      end
      else
      begin
         if (full_wrap)
         begin
            count_low_r  <= reload_low_r;
            count_high_r <= reload_high_r;
         end
         else
         begin
            if (req.wr && req.addr == ART_ADDR_COUNT_LOW)
            begin
               count_low_r <= req.wdata;
            end
            else if (split && low_wrap)
            begin
               count_low_r <= reload_low_r;
            end
            else if (low_step)
            begin
               count_low_r <= count_low_r + ART_BYTE_ONE;
            end

            if (req.wr && req.addr == ART_ADDR_COUNT_HIGH)
            begin
               count_high_r <= req.wdata;
            end
            else if (split && high_wrap)
            begin
               count_high_r <= reload_high_r;
            end
            else if (split ? high_step : low_wrap)
            begin
               count_high_r <= count_high_r + ART_BYTE_ONE;
            end
         end
      end
   end

   // Capture takes priority over a software write in the same cycle
   always_ff @(posedge core_clk_in)
   begin
      if (!rstn_in)
      begin
         reload_low_r  <= ART_RESET_BYTE;
         reload_high_r <= ART_RESET_BYTE;
      end
      else if (capture_evt)
      begin
         reload_low_r  <= count_low_r;
         reload_high_r <= count_high_r;
      end
      else if (req.wr)
      begin
         if (req.addr == ART_ADDR_RELOAD_LOW)
         begin
            reload_low_r <= req.wdata;
         end
         if (req.addr == ART_ADDR_RELOAD_HIGH)
         begin
            reload_high_r <= req.wdata;
         end
      end
   end

   assign high_flag_set = high_wrap | capture_evt;
   assign low_flag_set  = low_wrap;

   // flags cleared only by software; a set in the same cycle wins
   always_ff @(posedge core_clk_in)
   begin
      if (!rstn_in)
      begin
         control_r <= ART_RESET_BYTE;
      end
      else
      begin
         if (wr_control)
         begin
            control_r <= req.wdata & ART_CONTROL_WMASK;
         end
         if (high_flag_set)
         begin
            control_r[ART_BIT_HIGH_FLAG] <= 1'b1;
         end
         if (low_flag_set)
         begin
            control_r[ART_BIT_LOW_FLAG] <= 1'b1;
         end
      end
   end

   // high flag drives request; add the low flag when its enable bit 5 is set
   assign irq_nxt = timer_interrupt_enable_in &
                    (control_r[ART_BIT_HIGH_FLAG] |
                     (control_r[ART_BIT_LOW_IEN] & control_r[ART_BIT_LOW_FLAG]));

   // level request held while the flag stands
   always_ff @(posedge core_clk_in)
   begin
      if (!rstn_in)
      begin
         timer_irq_r <= 1'b0;
      end
      else
      begin
         timer_irq_r <= irq_nxt;
      end
   end

   // Registered read data; unmapped addresses read zero
   always_ff @(posedge core_clk_in)
   begin
      if (!rstn_in)
      begin
         sfr_rdata_r <= ART_RESET_BYTE;
      end
      else if (req.rd)
      begin
         case (req.addr)
            ART_ADDR_CONTROL:     sfr_rdata_r <= control_r;
            ART_ADDR_RELOAD_LOW:  sfr_rdata_r <= reload_low_r;
            ART_ADDR_RELOAD_HIGH: sfr_rdata_r <= reload_high_r;
            ART_ADDR_COUNT_LOW:   sfr_rdata_r <= count_low_r;
            ART_ADDR_COUNT_HIGH:  sfr_rdata_r <= count_high_r;
            default:              sfr_rdata_r <= ART_RESET_BYTE;
         endcase
      end
   end

   assign sfr_rdata_out = sfr_rdata_r;
   assign timer_irq_out = timer_irq_r;

endmodule

// ===== verification/art_timer_sva.sv
`timescale 1ns/1ps
module art_timer_sva
   import art_pkg::*;
(
   // Clock and reset
   input wire logic       core_clk_in,
   input wire logic       rstn_in,
   // Register access
   input wire logic       sfr_wr_in,
   input wire logic       sfr_rd_in,
   input wire logic [7:0] sfr_addr_in,
   input wire logic [7:0] sfr_wdata_in,
   input wire logic [7:0] sfr_rdata_out,
   // Clock selects, enable, external clock, request
   input wire logic       high_byte_clock_select_in,
   input wire logic       low_byte_clock_select_in,
   input wire logic       timer_interrupt_enable_in,
   input wire logic       ext_div8_in,
   input wire logic       timer_irq_out
);
   default clocking @(posedge core_clk_in);
   endclocking
   default disable iff (!rstn_in);

   property p_rst;
      $rose(rstn_in) |-> sfr_rdata_out == 8'h00 && !timer_irq_out;
   endproperty
   a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
   property p_bit1;
      sfr_rd_in && sfr_addr_in == ART_ADDR_CONTROL |=> !sfr_rdata_out[1];
   endproperty
   a_bit1: assert property (p_bit1) else $error("control bit 1 read as one");
   // Flags may set meanwhile, so only the lower six bits are compared
   property p_ctl;
      sfr_wr_in && sfr_addr_in == ART_ADDR_CONTROL ##1 !sfr_wr_in ##1
      sfr_rd_in && !sfr_wr_in && sfr_addr_in == ART_ADDR_CONTROL |=>
      (sfr_rdata_out & 8'h3F) == ($past(sfr_wdata_in, 3) & ART_CONTROL_WMASK & 8'h3F);
   endproperty
   a_ctl: assert property (p_ctl) else $error("control readback wrong");
   property p_unm;
      sfr_rd_in && !(sfr_addr_in inside {8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD})
      |=> sfr_rdata_out == 8'h00;
   endproperty
   a_unm: assert property (p_unm) else $error("unmapped read not zero");
   property p_ien;
      !timer_interrupt_enable_in |=> !timer_irq_out;
   endproperty
   a_ien: assert property (p_ien) else $error("request while disabled");
   property p_hold;
      timer_irq_out && timer_interrupt_enable_in && !$past(sfr_wr_in) |=> timer_irq_out;
   endproperty
   a_hold: assert property (p_hold) else $error("request dropped by itself");
   property p_fell;
      $fell(timer_irq_out) |-> $past(sfr_wr_in, 2) || !$past(timer_interrupt_enable_in);
   endproperty
   a_fell: assert property (p_fell) else $error("request fell without cause");
   property p_rose;
      $rose(timer_irq_out) |-> $past(timer_interrupt_enable_in);
   endproperty
   a_rose: assert property (p_rose) else $error("request rose while disabled");

   c_irq: cover property ($rose(timer_irq_out));
   c_ctl: cover property (sfr_rd_in && sfr_addr_in == ART_ADDR_CONTROL);
   c_unm: cover property (sfr_rd_in && sfr_addr_in == 8'hC9);
endmodule

bind art_timer art_timer_sva u_sva (
   .core_clk_in, .rstn_in, .sfr_wr_in, .sfr_rd_in, .sfr_addr_in, .sfr_wdata_in,
   .sfr_rdata_out, .high_byte_clock_select_in, .low_byte_clock_select_in,
   .timer_interrupt_enable_in, .ext_div8_in, .timer_irq_out
);

// ===== verification/art_timer_tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) \
   begin \
      comparisons++; \
      if ((g) !== (e)) \
      begin \
         fail_count++; \
         $display("BAD %s exp %h got %h", n, e, g); \
      end \
   end
module art_timer_tb_top
   import art_pkg::*;
;
   logic       core_clk_in = 1'b0;
   logic       rstn_in = 1'b0;
   logic       sfr_wr_in = 1'b0;
   logic       sfr_rd_in = 1'b0;
   logic [7:0] sfr_addr_in = 8'h00;
   logic [7:0] sfr_wdata_in = 8'h00;
   logic [7:0] sfr_rdata_out;
   logic       high_byte_clock_select_in = 1'b0;
   logic       low_byte_clock_select_in = 1'b0;
   logic       timer_interrupt_enable_in = 1'b0;
   logic       ext_div8_in = 1'b0;
   logic       timer_irq_out;
   int         fail_count = 0;
   int         comparisons = 0;

   art_timer dut (
      .core_clk_in, .rstn_in, .sfr_wr_in, .sfr_rd_in, .sfr_addr_in, .sfr_wdata_in,
      .sfr_rdata_out, .high_byte_clock_select_in, .low_byte_clock_select_in,
      .timer_interrupt_enable_in, .ext_div8_in, .timer_irq_out
   );

   always #20 core_clk_in = ~core_clk_in;

   task automatic conclude;
      $display("mismatches %0d comparisons %0d", fail_count, comparisons);
      if (fail_count == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk_in);
      sfr_wr_in = 1'b1;
      sfr_addr_in = a;
      sfr_wdata_in = d;
      @(negedge core_clk_in);
      sfr_wr_in = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
      @(negedge core_clk_in);
      sfr_rd_in = 1'b1;
      sfr_addr_in = a;
      @(negedge core_clk_in);
      sfr_rd_in = 1'b0;
      `CHK("rdata", e, sfr_rdata_out & m)
   endtask

   // Bounded wait; running out ends the run at once
   task automatic wirq(input logic e, input int n);
      for (int i = 0; i < n && timer_irq_out !== e; i++)
         @(negedge core_clk_in);
      `CHK("irq", e, timer_irq_out)
      if (timer_irq_out !== e)
         conclude();
   endtask

   initial
   begin
      repeat (4) @(negedge core_clk_in);
      rstn_in = 1'b1;
      for (int i = 0; i < 8; i++)
         rd(8'hC8 + 8'(i), 8'h00, 8'hFF); // reset values
      wr(8'hC9, 8'h5A);
      rd(8'hC9, 8'h00, 8'hFF); // unmapped
      wr(8'hCA, 8'h34);
      wr(8'hCB, 8'h12);
      rd(8'hCA, 8'h34, 8'hFF); // reload low
      rd(8'hCB, 8'h12, 8'hFF); // reload high
      wr(8'hC8, 8'h02);
      rd(8'hC8, 8'h00, 8'hFF); // unused bit
      wr(8'hC8, 8'h21);
      rd(8'hC8, 8'h21, 8'hFF); // control readback
      low_byte_clock_select_in = 1'b1;
      wr(8'hC8, 8'h00);
      wr(8'hCA, 8'hFE);
      wr(8'hCB, 8'hFF);
      wr(8'hCC, 8'hFE);
      wr(8'hCD, 8'hFF);
      wr(8'hC8, 8'h04); // low enable clear
      repeat (4) @(negedge core_clk_in);
      rd(8'hC8, 8'hC4, 8'hFF); // both flags
      `CHK("irq", 1'b0, timer_irq_out) // disabled
      timer_interrupt_enable_in = 1'b1;
      wirq(1'b1, 4); // request
      rd(8'hCD, 8'hFF, 8'hFF); // reload high
      rd(8'hCC, 8'hFE, 8'hFE); // low range
      repeat (20) @(negedge core_clk_in);
      `CHK("irq", 1'b1, timer_irq_out) // flag stands
      // Stop first: a wrap in the clearing cycle would set the flag again
      wr(8'hC8, 8'h00);
      wr(8'hC8, 8'h00);
      wirq(1'b0, 4); // software clear
      wr(8'hCD, 8'h00);
      wr(8'hCC, 8'hFE);
      wr(8'hC8, 8'h04);
      repeat (8) @(negedge core_clk_in);
      rd(8'hC8, 8'h44, 8'hFF); // low flag only
      `CHK("irq", 1'b0, timer_irq_out) // low enable clear
      wr(8'hC8, 8'h24);
      wirq(1'b1, 300); // low wrap request
      rd(8'hC8, 8'h64, 8'hFF);
      high_byte_clock_select_in = 1'b1;
      wr(8'hC8, 8'h00);
      wr(8'hCA, 8'hF0);
      wr(8'hCD, 8'h05);
      wr(8'hCC, 8'hFE);
      wr(8'hC8, 8'h08);
      repeat (8) @(negedge core_clk_in);
      rd(8'hCD, 8'h05, 8'hFF); // high stopped
      rd(8'hCC, 8'hF0, 8'hF0); // low reload
      rd(8'hC8, 8'h48, 8'hFF); // low flag
      `CHK("irq", 1'b0, timer_irq_out) // low not enabled
      wr(8'hC8, 8'h28);
      wirq(1'b1, 40); // low byte enabled
      wr(8'hCB, 8'hFE);
      wr(8'hCD, 8'hFE);
      wr(8'hC8, 8'h0C);
      repeat (4) @(negedge core_clk_in);
      rd(8'hC8, 8'h80, 8'h80); // high flag
      rd(8'hCD, 8'hFE, 8'hFE); // high reload
      wirq(1'b1, 4); // high request
      wr(8'hC8, 8'h08);
      high_byte_clock_select_in = 1'b0;
      wr(8'hCD, 8'h00);
      wr(8'hC8, 8'h0C);
      repeat (24) @(negedge core_clk_in);
      // 25 counting edges hold two or three prescaler pulses
      rd(8'hCD, 8'h02, 8'hFE); // divided clock
      wr(8'hC8, 8'h08);
      wr(8'hCD, 8'h00);
      wr(8'hC8, 8'h0D);
      repeat (3)
      begin
         ext_div8_in = 1'b1;
         repeat (4) @(negedge core_clk_in);
         ext_div8_in = 1'b0;
         repeat (4) @(negedge core_clk_in);
      end
      rd(8'hCD, 8'h03, 8'hFF); // external clock
      wr(8'hC8, 8'h00);
      wr(8'hCD, 8'h10);
      wr(8'hCC, 8'h00);
      wr(8'hC8, 8'h14); // 16-bit mode kept
      ext_div8_in = 1'b1;
      repeat (6) @(negedge core_clk_in);
      ext_div8_in = 1'b0;
      repeat (8) @(negedge core_clk_in);
      rd(8'hC8, 8'h80, 8'h80); // capture flag
      rd(8'hCB, 8'h10, 8'hFF); // captured high
      // Count 0x1008 is taken three edges after the pin falls
      rd(8'hCA, 8'h08, 8'hFF); // falling edge capture
      rstn_in = 1'b0;
      repeat (2) @(negedge core_clk_in);
      rstn_in = 1'b1;
      rd(8'hC8, 8'h00, 8'hFF); // mid-run reset control
      rd(8'hCB, 8'h00, 8'hFF); // mid-run reset reload
      `CHK("irq", 1'b0, timer_irq_out) // mid-run reset request
      conclude();
   end
endmodule
